// ==== src/mccr_regs.vh ====
// Register map, field positions, reset values and timing for the metering config block
`ifndef MCCR_REGS_VH
`define MCCR_REGS_VH

`define MCCR_ADDR_W 12
`define MCCR_DATA_W 16

`define MCCR_OFF_GEN_CFG_ONE 12'h481
`define MCCR_OFF_OC_STATUS 12'h48F
`define MCCR_OFF_PULSE_MODE 12'h490

`define MCCR_BURST_LO_A 12'h500
`define MCCR_BURST_HI_A 12'h63C
`define MCCR_BURST_LO_B 12'h680
`define MCCR_BURST_HI_B 12'h6BC

`define MCCR_CFG1_EXT_REF 15
`define MCCR_CFG1_IRQ_COMBINE 12
`define MCCR_CFG1_BURST 11
`define MCCR_CFG1_DS_MODE 10
`define MCCR_CFG1_SETTLE_HI 9
`define MCCR_CFG1_SETTLE_LO 8
`define MCCR_CFG1_ACC_CLR 5
`define MCCR_CFG1_PIN4_HI 3
`define MCCR_CFG1_PIN4_LO 2
`define MCCR_CFG1_PIN3 1
`define MCCR_CFG1_SOFT_RST 0
`define MCCR_CFG1_RW_MASK 16'h9F0E

`define MCCR_CFM_PIN4_DIS 15
`define MCCR_CFM_PIN3_DIS 14

`define MCCR_GEN_CFG_ONE_RST 16'h0000
`define MCCR_PULSE_MODE_RST 16'h0000

`define MCCR_PIN4_DATA_READY 2'h3
`define MCCR_PIN4_EVENT 2'h2

// Settling counts of 64, 128 and 256 ms at the 125 MHz system clock
`define MCCR_SETTLE_64_CYC 26'h7A1200
`define MCCR_SETTLE_128_CYC 26'hF42400
`define MCCR_SETTLE_256_CYC 26'h1E84800
`define MCCR_SETTLE_CNT_W 26

`endif

// ==== src/mccr_settle_timer.v ====
// Settling timer that holds off accumulation after reset
`timescale 1ns/1ps
`include "mccr_regs.vh"

module mccr_settle_timer #(
  parameter [`MCCR_SETTLE_CNT_W-1:0] CYC_64 = `MCCR_SETTLE_64_CYC,
  parameter [`MCCR_SETTLE_CNT_W-1:0] CYC_128 = `MCCR_SETTLE_128_CYC,
  parameter [`MCCR_SETTLE_CNT_W-1:0] CYC_256 = `MCCR_SETTLE_256_CYC
) (
  input wire clk,
  input wire rst,
  input wire [1:0] settle_sel,
  output reg settled_reg
);
  reg [`MCCR_SETTLE_CNT_W-1:0] count_reg;
  reg [`MCCR_SETTLE_CNT_W-1:0] limit;

  always @* begin
    case (settle_sel)
      2'h0: limit = CYC_64;
      2'h1: limit = CYC_128;
      2'h2: limit = CYC_256;
      default: limit = {`MCCR_SETTLE_CNT_W{1'b0}};
    endcase
  end

  // Selection is read live, so a shorter setting takes effect at once
  always @(posedge clk) begin
    if (rst) begin
      count_reg <= {`MCCR_SETTLE_CNT_W{1'b0}};
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      if (count_reg >= limit) begin
        settled_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + {{(`MCCR_SETTLE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== src/mccr_ctrl.v ====
// Configuration and control registers, pulse pin routing and settling control
`timescale 1ns/1ps
`include "mccr_regs.vh"

module mccr_ctrl #(
  parameter [`MCCR_SETTLE_CNT_W-1:0] SETTLE_64_CYC = `MCCR_SETTLE_64_CYC,
  parameter [`MCCR_SETTLE_CNT_W-1:0] SETTLE_128_CYC = `MCCR_SETTLE_128_CYC,
  parameter [`MCCR_SETTLE_CNT_W-1:0] SETTLE_256_CYC = `MCCR_SETTLE_256_CYC
) (
  input wire clk,
  input wire rst,
  input wire [`MCCR_ADDR_W-1:0] reg_addr,
  input wire [`MCCR_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`MCCR_DATA_W-1:0] reg_rdata_reg,
  output reg reg_rvalid_reg,
  output reg burst_allowed_reg,
  output reg crc_append_reg,
  input wire [1:0] dip_swell_active,
  input wire [1:0] dip_swell_cycles_done,
  output reg [1:0] dip_swell_irq_reg,
  output reg accum_enable_reg,
  output reg pulse_accumulator_clear_reg,
  output reg soft_reset_reg,
  input wire [3:0] overcurrent_phase_flags,
  input wire [1:0] dfc_pulse_level,
  input wire [1:0] dfc_pulse_event,
  input wire event_in,
  input wire data_ready_output,
  input wire zero_crossing_source,
  output reg third_pulse_pin_reg,
  output reg fourth_pulse_pin_reg,
  output reg [1:0] pulse_status_set_reg
);
  reg [`MCCR_DATA_W-1:0] general_config_one_reg;
  reg [`MCCR_DATA_W-1:0] pulse_output_mode_reg;
  reg [3:0] overcurrent_phase_status_reg;
  reg [1:0] dip_swell_prev_reg;
  wire dev_rst;
  wire settled;
  wire burst_en;
  wire ds_mode;
  wire [1:0] fourth_pin_function;
  wire third_pin_function;
  wire [1:0] output_disable;
  reg third_pin_next;
  reg fourth_pin_next;
  reg [`MCCR_DATA_W-1:0] rdata_next;

  function in_burst_window;
    input [`MCCR_ADDR_W-1:0] a;
    begin
      in_burst_window = ((a >= `MCCR_BURST_LO_A) && (a <= `MCCR_BURST_HI_A)) ||
                        ((a >= `MCCR_BURST_LO_B) && (a <= `MCCR_BURST_HI_B));
    end
  endfunction

  function reg_hit;
    input [`MCCR_ADDR_W-1:0] a;
    input [`MCCR_ADDR_W-1:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  // Software reset acts one cycle after the write, like a device reset
  assign dev_rst = rst | soft_reset_reg;
  assign burst_en = general_config_one_reg[`MCCR_CFG1_BURST];
  assign ds_mode = general_config_one_reg[`MCCR_CFG1_DS_MODE];
  assign fourth_pin_function = general_config_one_reg[`MCCR_CFG1_PIN4_HI:`MCCR_CFG1_PIN4_LO];
  assign third_pin_function = general_config_one_reg[`MCCR_CFG1_PIN3];
  assign output_disable = {pulse_output_mode_reg[`MCCR_CFM_PIN4_DIS],
                           pulse_output_mode_reg[`MCCR_CFM_PIN3_DIS]};

  mccr_settle_timer #(
    .CYC_64(SETTLE_64_CYC),
    .CYC_128(SETTLE_128_CYC),
    .CYC_256(SETTLE_256_CYC)
  ) u_settle (
    .clk(clk),
    .rst(dev_rst),
    .settle_sel(general_config_one_reg[`MCCR_CFG1_SETTLE_HI:`MCCR_CFG1_SETTLE_LO]),
    .settled_reg(settled)
  );

  // Register writes; self-clearing bits are never stored
  always @(posedge clk) begin
    if (dev_rst) begin
      general_config_one_reg <= `MCCR_GEN_CFG_ONE_RST;
      pulse_output_mode_reg <= `MCCR_PULSE_MODE_RST;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, `MCCR_OFF_GEN_CFG_ONE)) begin
        general_config_one_reg <= reg_wdata & `MCCR_CFG1_RW_MASK;
      end
      if (reg_hit(reg_addr, `MCCR_OFF_PULSE_MODE)) begin
        pulse_output_mode_reg <= reg_wdata;
      end
    end
  end

  // Only plain rst clears the reset pulse so it cannot hold itself
  always @(posedge clk) begin
    if (rst) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= !soft_reset_reg && reg_wr && reg_hit(reg_addr, `MCCR_OFF_GEN_CFG_ONE) &&
                        reg_wdata[`MCCR_CFG1_SOFT_RST];
    end
  end

  always @(posedge clk) begin
    if (dev_rst) begin
      pulse_accumulator_clear_reg <= 1'b0;
    end else begin
      pulse_accumulator_clear_reg <= reg_wr && reg_hit(reg_addr, `MCCR_OFF_GEN_CFG_ONE) &&
                                     reg_wdata[`MCCR_CFG1_ACC_CLR];
    end
  end

  always @* begin
    rdata_next = {`MCCR_DATA_W{1'b0}};
    if (reg_hit(reg_addr, `MCCR_OFF_GEN_CFG_ONE)) begin
      rdata_next = general_config_one_reg;
    end else if (reg_hit(reg_addr, `MCCR_OFF_OC_STATUS)) begin
      rdata_next = {12'h000, overcurrent_phase_status_reg};
    end else if (reg_hit(reg_addr, `MCCR_OFF_PULSE_MODE)) begin
      rdata_next = pulse_output_mode_reg;
    end
  end

  // Read port; unmapped addresses return zero
  always @(posedge clk) begin
    if (dev_rst) begin
      reg_rdata_reg <= {`MCCR_DATA_W{1'b0}};
      reg_rvalid_reg <= 1'b0;
      burst_allowed_reg <= 1'b0;
      crc_append_reg <= 1'b1;
      overcurrent_phase_status_reg <= 4'h0;
    end else begin
      overcurrent_phase_status_reg <= overcurrent_phase_flags;
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rdata_next;
      end
      burst_allowed_reg <= burst_en && in_burst_window(reg_addr);
      crc_append_reg <= !burst_en;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ds
      // Mode 0 repeats every count; mode 1 fires on entry and exit only
      always @(posedge clk) begin
        if (dev_rst) begin
          dip_swell_prev_reg[i] <= 1'b0;
          dip_swell_irq_reg[i] <= 1'b0;
        end else begin
          dip_swell_prev_reg[i] <= dip_swell_active[i];
          if (ds_mode) begin
            dip_swell_irq_reg[i] <= dip_swell_active[i] ^ dip_swell_prev_reg[i];
          end else begin
            dip_swell_irq_reg[i] <= dip_swell_active[i] && dip_swell_cycles_done[i];
          end
        end
      end

      // Index 0 is the third pin, index 1 the fourth
      always @(posedge clk) begin
        if (dev_rst) begin
          pulse_status_set_reg[i] <= 1'b0;
        end else begin
          pulse_status_set_reg[i] <= dfc_pulse_event[i] && !output_disable[i] &&
                                     settled;
        end
      end
    end
  endgenerate

  always @* begin
    if (third_pin_function) begin
      third_pin_next = zero_crossing_source;
    end else begin
      third_pin_next = dfc_pulse_level[0];
    end
    case (fourth_pin_function)
      `MCCR_PIN4_DATA_READY: fourth_pin_next = data_ready_output;
      `MCCR_PIN4_EVENT: fourth_pin_next = event_in;
      default: fourth_pin_next = dfc_pulse_level[1];
    endcase
    // Pulse pins idle high, so a disabled pin is parked high
    if (output_disable[0]) begin
      third_pin_next = 1'b1;
    end
    if (output_disable[1]) begin
      fourth_pin_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (dev_rst) begin
      third_pulse_pin_reg <= 1'b1;
      fourth_pulse_pin_reg <= 1'b1;
      accum_enable_reg <= 1'b0;
    end else begin
      third_pulse_pin_reg <= third_pin_next;
      fourth_pulse_pin_reg <= fourth_pin_next;
      accum_enable_reg <= settled;
    end
  end
endmodule

// ==== bench/mccr_ctrl_asserts.sv ====
// Port checker for the config and control block
`timescale 1ns/1ps
`include "mccr_regs.vh"
module mccr_chk (
  input wire clk,
  input wire rst,
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_reg,
  input wire reg_rvalid_reg,
  input wire burst_allowed_reg,
  input wire crc_append_reg,
  input wire accum_enable_reg,
  input wire pulse_accumulator_clear_reg,
  input wire soft_reset_reg,
  input wire [3:0] overcurrent_phase_flags,
  input wire third_pulse_pin_reg,
  input wire fourth_pulse_pin_reg,
  input wire [1:0] pulse_status_set_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire w_cfg = reg_wr && reg_addr == `MCCR_OFF_GEN_CFG_ONE;
  wire w_cfm = reg_wr && reg_addr == `MCCR_OFF_PULSE_MODE;
  wire in_rng = (reg_addr >= 12'h500 && reg_addr <= 12'h63C) ||
    (reg_addr >= 12'h680 && reg_addr <= 12'h6BC);
  burst_range_a: assert property (burst_allowed_reg |-> $past(in_rng)) else $error("burst");
  crc_off_a: assert property (burst_allowed_reg |-> !crc_append_reg) else $error("crc");
  dis_four_a: assert property (
    w_cfm && reg_wdata[15] ##1 !reg_wr |-> ##1 fourth_pulse_pin_reg) else $error("pin4");
  dis_three_a: assert property (
    w_cfm && reg_wdata[14] ##1 !reg_wr |-> ##1 third_pulse_pin_reg) else $error("pin3");
  stat_gate_a: assert property (
    w_cfm && reg_wdata[15] ##1 !reg_wr |-> ##1 !pulse_status_set_reg[1]) else $error("stat");
  acc_clear_a: assert property (
    w_cfg && reg_wdata[5] && !reg_wdata[0] |=> pulse_accumulator_clear_reg) else $error("clr");
  soft_rst_a: assert property (
    w_cfg && reg_wdata[0] |=> soft_reset_reg ##1 !soft_reset_reg) else $error("software_reset_bit");
  // Status word is sampled into a register before the read picks it up
  oc_read_a: assert property (
    reg_rd && reg_addr == `MCCR_OFF_OC_STATUS |=>
    reg_rdata_reg == {12'h000, $past(overcurrent_phase_flags, 2)}) else $error("oc");
  settle_hold_a: assert property (
    soft_reset_reg |=> !accum_enable_reg [*8]) else $error("settle");
  read_valid_a: assert property (!soft_reset_reg |=> reg_rvalid_reg == $past(reg_rd))
    else $error("rvalid");
endmodule
bind mccr_ctrl mccr_chk chk_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_reg, .reg_rvalid_reg, .burst_allowed_reg, .crc_append_reg, .accum_enable_reg,
  .pulse_accumulator_clear_reg, .soft_reset_reg, .overcurrent_phase_flags,
  .third_pulse_pin_reg, .fourth_pulse_pin_reg, .pulse_status_set_reg);

// ==== bench/mccr_host_model.sv ====
// Host model on the register word port
`timescale 1ns/1ps
module mccr_host_model (
  input wire clk,
  input wire [15:0] reg_rdata_reg,
  output reg [11:0] reg_addr,
  output reg [15:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 30'h0;
  end
  task put(input [11:0] a);
    begin
      @(negedge clk);
      reg_addr = a;
    end
  endtask
  // Released lines show inverted data, never the last value
  task wr(input [11:0] a, input [15:0] d);
    begin
      @(negedge clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk);
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    end
  endtask
  task rd(input [11:0] a, output [15:0] d);
    begin
      @(negedge clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk);
      {reg_addr, reg_rd} = {~a, 1'b0};
      @(negedge clk);
      d = reg_rdata_reg;
    end
  endtask
endmodule

// ==== bench/tb_metering_config_control_regs.sv ====
// Self-checking bench for the config and control block
`timescale 1ns/1ps
`include "mccr_regs.vh"
module tb_metering_config_control_regs;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] act, done, lvl, ev, pa;
  reg [3:0] oc;
  reg evi, dr, zx;
  reg [15:0] d, w, c1, cm;
  reg [31:0] rnd_word;
  wire [11:0] addr;
  wire [15:0] wdata, rdata;
  wire [1:0] irq, stat;
  wire wr, rd, rv, burst, crc, acc, clr, srst, pin3, pin4;
  integer seed = 32'hdee76b06;
  integer err_total = 0;
  integer cmp_count = 0;
  integer k, i;
  always #4 clk = ~clk;
  mccr_host_model host_u (.clk(clk), .reg_rdata_reg(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  mccr_ctrl #(.SETTLE_64_CYC(26'h14), .SETTLE_128_CYC(26'h28), .SETTLE_256_CYC(26'h50)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_reg(rdata), .reg_rvalid_reg(rv), .burst_allowed_reg(burst),
    .crc_append_reg(crc), .dip_swell_active(act), .dip_swell_cycles_done(done),
    .dip_swell_irq_reg(irq), .accum_enable_reg(acc), .pulse_accumulator_clear_reg(clr),
    .soft_reset_reg(srst), .overcurrent_phase_flags(oc), .dfc_pulse_level(lvl),
    .dfc_pulse_event(ev), .event_in(evi), .data_ready_output(dr), .zero_crossing_source(zx),
    .third_pulse_pin_reg(pin3), .fourth_pulse_pin_reg(pin4), .pulse_status_set_reg(stat));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [11:0] a, input [15:0] exp);
    begin
      host_u.rd(a, d);
      chk(d, exp);
    end
  endtask
  task rnd;
    begin
      pa = act;
      rnd_word = $random(seed);
      {act, done, oc, lvl, ev, evi, dr, zx} = rnd_word[14:0];
    end
  endtask
  function [1:0] pins(input [15:0] g, input [15:0] m);
    begin
      pins[0] = m[14] | (g[1] ? zx : lvl[0]);
      pins[1] = m[15] | (g[3:2] == 2'h3 ? dr : (g[3:2] == 2'h2 ? evi : lvl[1]));
    end
  endfunction
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    rnd;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (15) @(negedge clk);
    chk(acc, 16'h0);
    repeat (10) @(negedge clk);
    chk({acc, pin4, pin3, crc}, {12'h000, 1'b1, pins(16'h0000, 16'h0000), 1'b1});
    rchk(12'h123, 16'h0000);
    host_u.wr(`MCCR_OFF_OC_STATUS, 16'hFFFF);
    rchk(`MCCR_OFF_OC_STATUS, {12'h000, oc});
    for (k = 0; k < 4; k = k + 1) begin
      rnd_word = $random(seed);
      w = rnd_word[15:0];
      host_u.wr(`MCCR_OFF_GEN_CFG_ONE, w & 16'hFFFE);
      rchk(`MCCR_OFF_GEN_CFG_ONE, w & `MCCR_CFG1_RW_MASK);
      host_u.wr(`MCCR_OFF_PULSE_MODE, w);
      rchk(`MCCR_OFF_PULSE_MODE, w);
    end
    host_u.wr(`MCCR_OFF_GEN_CFG_ONE, 16'h0B00);
    for (k = 0; k < 8; k = k + 1) begin
      w[11:0] = k[1] ? (k[2] ? 12'h6BC : 12'h63C) : (k[2] ? 12'h680 : 12'h500);
      host_u.put(w[11:0] + (k[0] ? (k[1] ? 12'h001 : 12'hFFF) : 12'h000));
      repeat (2) @(negedge clk);
      chk({burst, crc}, {~k[0], 1'b0});
    end
    host_u.wr(`MCCR_OFF_GEN_CFG_ONE, 16'h0300);
    @(negedge clk);
    chk(crc, 16'h1);
    for (k = 0; k < 16; k = k + 1) begin
      c1 = {5'h00, k[3], 6'h30, k[2:0], 1'b0};
      cm = {k[0] ^ k[3], k[1], 14'h0000};
      host_u.wr(`MCCR_OFF_GEN_CFG_ONE, c1);
      host_u.wr(`MCCR_OFF_PULSE_MODE, cm);
      pa = act;
      for (i = 0; i < 6; i = i + 1) begin
        @(negedge clk);
        chk({pin4, pin3}, pins(c1, cm));
        chk(irq, c1[10] ? act ^ pa : act & done);
        chk(stat, ev & ~cm[15:14]);
        rnd;
      end
    end
    host_u.wr(`MCCR_OFF_GEN_CFG_ONE, 16'h0020);
    chk(clr, 16'h1);
    rchk(`MCCR_OFF_GEN_CFG_ONE, 16'h0000);
    chk(clr, 16'h0);
    host_u.wr(`MCCR_OFF_PULSE_MODE, 16'hC000);
    host_u.wr(`MCCR_OFF_GEN_CFG_ONE, 16'h0401);
    chk(srst, 16'h1);
    rchk(`MCCR_OFF_GEN_CFG_ONE, 16'h0000);
    rchk(`MCCR_OFF_PULSE_MODE, 16'h0000);
    chk({srst, acc}, 16'h0);
    // Longer setting chosen while counting; the short limit would already be met
    host_u.wr(`MCCR_OFF_GEN_CFG_ONE, 16'h0100);
    repeat (20) @(negedge clk);
    chk(acc, 16'h0);
    repeat (20) @(negedge clk);
    chk(acc, 16'h1);
    tally_and_finish;
  end
endmodule
